// ===== verif/usc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port-level checks on the serial unit
module usc_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_output_line,
  input wire logic        transfer_clock_pin_oe
);
  logic txen_r, sync_r, xdir_r, bad_r;
  wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Shadow of config bits; it leads the pins by two edges, so off is checked once settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {txen_r, sync_r, xdir_r, bad_r} <= 4'h0;
    end else if (wr_go) begin
      bad_r <= s_axi_awaddr > 8'h13;
      if (s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[0])
        {xdir_r, sync_r, txen_r} <= {s_axi_wdata[4], s_axi_wdata[2], s_axi_wdata[0]};
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst; $rose(aresetn) |-> serial_output_line && !transfer_clock_pin_oe && !s_axi_bvalid; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_txoff; !txen_r && !$past(txen_r, 3) |-> serial_output_line; endproperty
  a_txoff: assert property (p_txoff) else $error("line low while transmitter off");
  property p_async; !sync_r && !$past(sync_r, 3) |-> !transfer_clock_pin_oe; endproperty
  a_async: assert property (p_async) else $error("clock pin driven in async mode");
  property p_dir; !xdir_r && !$past(xdir_r, 3) |-> !transfer_clock_pin_oe; endproperty
  a_dir: assert property (p_dir) else $error("clock pin driven as input");
  property p_bans; wr_go |=> !s_axi_awready ##1 s_axi_bvalid; endproperty
  a_bans: assert property (p_bans) else $error("write response late");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rans: assert property (p_rans) else $error("read data late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_slverr; s_axi_bvalid |-> s_axi_bresp == (bad_r ? 2'b10 : 2'b00); endproperty
  a_slverr: assert property (p_slverr) else $error("wrong write response code");
endmodule // usc_checker

bind usc_core usc_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .serial_output_line, .transfer_clock_pin_oe);
`default_nettype wire

// ===== verif/usc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench for the serial unit
module usc_core_tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v, dv;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        serial_output_line, transfer_clock_pin_o, transfer_clock_pin_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [12:0] f;
  logic [12:0] cfg [5] = '{13'h00C3, 13'h0C0B, 13'h17C3, 13'h0683, 13'h08EF};
  int          failures = 0, total_checks = 0, k, n, bt;
  wire logic   serial_input_line;
  wire logic   xck_line;
  // Pin follows the remote clock whenever the unit does not drive it
  wire logic   transfer_clock_pin_i = transfer_clock_pin_oe ? transfer_clock_pin_o : xck_line;

  always #25 aclk = ~aclk;

  usc_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serial_input_line, .serial_output_line, .transfer_clock_pin_i,
    .transfer_clock_pin_o, .transfer_clock_pin_oe);
  usc_remote u_rem (.aclk, .rx_line(serial_input_line), .xck_line);

  // ==========
  // Verdict and helpers
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Wait guard: a hang counts as a mismatch
  task automatic lim(ref int c);
    c++;
    if (c > 3000) begin
      failures++;
      conclude();
    end
  endtask
  // Ready is looked at mid-cycle, release lands after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    int c = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      lim(c);
    end while (!b_t);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_t, r_t;
    int c = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      rd_v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      lim(c);
    end while (!r_t);
  endtask
  // Expected frame from a control word; stop bits stay as idle ones
  function automatic void frm(input logic [12:0] c, input logic [8:0] d);
    int nb;
    nb = (c[8:6] == 3'd7) ? 9 : (c[8:6] > 3'd3) ? 8 : c[8:6] + 5;
    dv = d & (9'h1FF >> (9 - nb));
    f = 13'h1FFE;
    for (int i = 0; i < nb; i++) f[i + 1] = d[i];
    k = nb + 1;
    if (c[10]) f[k++] = ^dv[8:0] ^ c[9];
    k = k + (c[11] ? 2 : 1);
  endfunction
  // Sample the transmit line at bit centres
  task automatic grab();
    n = 0;
    while (serial_output_line === 1'b1) begin
      @(negedge aclk);
      lim(n);
    end
    repeat (bt / 2) @(negedge aclk);
    for (int j = 0; j < k; j++) begin
      chk("tx bit", serial_output_line, f[j]);
      repeat (bt) @(negedge aclk);
    end
    @(posedge aclk);
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00);
    chk("ctrl reset", rd_v, 32'h0);
    rd(8'h10);
    chk("status reset", rd_v, 32'h1);
    rd(8'h14);
    chk("unmapped read", resp, 2'b10);
    wr(8'h14, 32'hFFFF);
    chk("unmapped write", resp, 2'b10);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h1);
    foreach (cfg[i]) begin
      wr(8'h00, cfg[i]);
      bt = cfg[i][2] ? 8 : cfg[i][3] ? 16 : 32;
      frm(cfg[i], {cfg[i][12], 8'hA5});
      wr(8'h0C, 32'hA5);
      grab();
      f[k - 1] = 1'b0;
      if (cfg[i][2]) @(negedge xck_line);
      u_rem.send(f, k, bt);
      n = 0;
      do begin
        rd(8'h10);
        lim(n);
      end while (rd_v[2] !== 1'b1);
      chk("frame error", rd_v[3], !cfg[i][11]);
      chk("parity error", rd_v[4], 1'b0);
      rd(8'h0C);
      chk("rx data", rd_v, dv);
      // A zeroed stop may open a further frame; let it run out, then clear it
      repeat ((k + 1) * bt) @(posedge aclk);
      rd(8'h10);
      if (rd_v[2]) rd(8'h0C);
    end
    wr(8'h00, 32'h00DD);
    @(negedge aclk);
    chk("pin drive", transfer_clock_pin_oe, 1'b1);
    n = 0;
    while (transfer_clock_pin_o !== 1'b0 && n < 99) begin @(negedge aclk); n++; end
    while (transfer_clock_pin_o !== 1'b1 && n < 99) begin @(negedge aclk); n++; end
    n = 0;
    while (transfer_clock_pin_o === 1'b1 && n < 99) begin @(negedge aclk); n++; end
    while (transfer_clock_pin_o === 1'b0 && n < 99) begin @(negedge aclk); n++; end
    chk("clock period", n, 4);
    conclude();
  end
endmodule // usc_core_tb
`default_nettype wire

// ===== verif/usc_remote.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Remote transmitter driving the receive line
module usc_remote (
  input wire logic aclk,
  output var logic rx_line,
  output var logic xck_line
);
  logic [1:0] xck_ph = 2'h0;
  // Idle line rests high
  initial rx_line = 1'b1;
  // Free-running link clock at an eighth of aclk, margin under the quarter-rate limit
  initial xck_line = 1'b0;
  always @(posedge aclk) begin
    xck_ph <= xck_ph + 2'h1;
    if (xck_ph == 2'h3) xck_line <= ~xck_line;
  end
  // Frame bits go out start first; bit time set by caller for slow or fast links
  task automatic send(input logic [12:0] f, input int k, input int bt);
    for (int j = 0; j < k; j++) begin
      rx_line <= f[j];
      repeat (bt) @(posedge aclk);
    end
    rx_line <= 1'b1;
  endtask
endmodule // usc_remote
`default_nettype wire

// ===== verilog/usc_baud_gen.v
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Baud rate down-counter
module usc_baud_gen #(
  parameter WIDTH = 12
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] divisor,
  input  wire             reload,
  output reg              tick_r
);

  reg [WIDTH-1:0] cnt_r;

  // Reload at zero or on a low-byte write; the write reload loads the old divisor, so a new rate takes effect from the next zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= {WIDTH{1'b0}};
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cnt_r == {WIDTH{1'b0}}) && !reload;
      if (reload || cnt_r == {WIDTH{1'b0}}) begin
        cnt_r <= divisor;
      end else begin
        cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // usc_baud_gen

`default_nettype wire

// ===== verilog/usc_core.v
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "usc_map.vh"

// =====================================================================
// Serial unit: clock modes, frame formatting, AXI4-Lite registers
module usc_core (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        serial_input_line,
  output reg         serial_output_line,
  input  wire        transfer_clock_pin_i,
  output reg         transfer_clock_pin_o,
  output reg         transfer_clock_pin_oe
);

  // ===================================================================
  // Helpers
  // Data bits per character; reserved size codes behave as eight
  function [3:0] data_bits;
    input [2:0] size;
    begin
      case (size)
        3'd0: data_bits = 4'd5;
        3'd1: data_bits = 4'd6;
        3'd2: data_bits = 4'd7;
        `USC_SIZE_NINE: data_bits = 4'd9;
        default: data_bits = 4'd8;
      endcase
    end
  endfunction

  // Parity over the used data bits only
  function par_calc;
    input [8:0] d;
    input [2:0] size;
    input       odd;
    reg   [8:0] m;
    begin
      m = d & ~(9'h1FF << data_bits(size));
      par_calc = (^m) ^ odd;
    end
  endfunction

  // ===================================================================
  // Registers
  reg  [12:0] ctrl_r;
  reg  [7:0]  baud_lo_r;
  reg  [3:0]  baud_hi_r;
  reg  [8:0]  txbuf_r;
  reg         txbuf_full_r;
  reg         tx_done_r;
  reg  [8:0]  rxdata_r;
  reg         rx_done_r;
  reg         frerr_r;
  reg         parerr_r;

  wire        tx_en    = ctrl_r[`USC_CTRL_TXEN];
  wire        rx_en    = ctrl_r[`USC_CTRL_RXEN];
  wire        sync_md  = ctrl_r[`USC_CTRL_SYNC];
  wire        dbl      = ctrl_r[`USC_CTRL_DBL];
  wire        xdir     = ctrl_r[`USC_CTRL_XDIR];
  wire        pol      = ctrl_r[`USC_CTRL_POL];
  wire [2:0]  csize    = ctrl_r[`USC_CTRL_SIZE_HI:`USC_CTRL_SIZE_LO];
  wire [1:0]  pmode    = ctrl_r[`USC_CTRL_PAR_HI:`USC_CTRL_PAR_LO];
  wire        stop2    = ctrl_r[`USC_CTRL_STOP2];
  wire        par_on   = pmode[1];
  wire        par_odd  = (pmode == `USC_PAR_ODD);
  wire [3:0]  nbits    = data_bits(csize);

  // ===================================================================
  // AXI4-Lite write channel
  reg         aw_got_r;
  reg         w_got_r;
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  wire        wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid;
  wire        wr_ctrl  = wr_fire && awaddr_r == `USC_OFS_CTRL;
  wire        wr_lo    = wr_fire && awaddr_r == `USC_OFS_BAUD_LO && wstrb_r[0];
  wire        wr_hi    = wr_fire && awaddr_r == `USC_OFS_BAUD_HI && wstrb_r[0];
  wire        wr_data  = wr_fire && awaddr_r == `USC_OFS_DATA && wstrb_r[0];
  wire        wr_stat  = wr_fire && awaddr_r == `USC_OFS_STATUS && wstrb_r[0];
  wire        wr_map   = awaddr_r == `USC_OFS_CTRL || awaddr_r == `USC_OFS_BAUD_LO ||
                         awaddr_r == `USC_OFS_BAUD_HI || awaddr_r == `USC_OFS_DATA ||
                         awaddr_r == `USC_OFS_STATUS;

  // Address and data taken in either order, answer after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `USC_RESP_OKAY;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end else if (!aw_got_r) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got_r) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
    end
  end

  // Configuration stores; software keeps them still while a frame runs
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= `USC_CTRL_RST;
      baud_lo_r <= 8'h00;
      baud_hi_r <= 4'h0;
    end else begin
      if (wr_ctrl && wstrb_r[0]) ctrl_r[7:0]  <= wdata_r[7:0];
      if (wr_ctrl && wstrb_r[1]) ctrl_r[12:8] <= wdata_r[12:8];
      if (wr_lo) baud_lo_r <= wdata_r[7:0];
      if (wr_hi) baud_hi_r <= wdata_r[3:0];
    end
  end

  // ===================================================================
  // AXI4-Lite read channel
  reg  [31:0] rd_word;
  reg         rd_ok;
  wire        rd_fire = s_axi_arready && s_axi_arvalid;
  wire        rd_data = rd_fire && {s_axi_araddr[7:2], 2'b00} == `USC_OFS_DATA;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `USC_OFS_CTRL:    rd_word[12:0] = ctrl_r;
      `USC_OFS_BAUD_LO: rd_word[7:0]  = baud_lo_r;
      `USC_OFS_BAUD_HI: rd_word[3:0]  = baud_hi_r;
      `USC_OFS_DATA:    rd_word[8:0]  = rxdata_r;
      `USC_OFS_STATUS:  rd_word[5:0]  = {rxdata_r[8], parerr_r, frerr_r,
                                         rx_done_r, tx_done_r, !txbuf_full_r};
      default:          rd_ok         = 1'b0;
    endcase
  end

  // One read at a time, answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `USC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ===================================================================
  // Clock generation
  wire        baud_tick;

  usc_baud_gen #(
    .WIDTH (12)
  ) u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor ({baud_hi_r, baud_lo_r}),
    .reload  (wr_lo),
    .tick_r  (baud_tick)
  );

  // Pin synchronisers; first stage feeds only the second
  reg         rxd_s1_r;
  reg         rxd_r;
  reg         xck_s1_r;
  reg         xck_s2_r;
  reg         xck_d_r;
  reg         xck_int_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rxd_s1_r  <= 1'b1;
      rxd_r     <= 1'b1;
      xck_s1_r  <= 1'b0;
      xck_s2_r  <= 1'b0;
      xck_d_r   <= 1'b0;
      xck_int_r <= 1'b0;
    end else begin
      rxd_s1_r <= serial_input_line;
      rxd_r    <= rxd_s1_r;
      xck_s1_r <= transfer_clock_pin_i;
      xck_s2_r <= xck_s1_r;
      xck_d_r  <= xck_s2_r;
      // Master clock: one half period per baud tick
      if (sync_md && xdir && baud_tick) xck_int_r <= !xck_int_r;
    end
  end

  // Edge events from the generator (master) or the detected pin (slave)
  wire        mst_rise = baud_tick && !xck_int_r;
  wire        mst_fall = baud_tick && xck_int_r;
  wire        slv_rise = xck_s2_r && !xck_d_r;
  wire        slv_fall = !xck_s2_r && xck_d_r;
  wire        x_rise   = xdir ? mst_rise : slv_rise;
  wire        x_fall   = xdir ? mst_fall : slv_fall;
  wire        chg_edge = pol ? x_fall : x_rise;
  wire        smp_edge = pol ? x_rise : x_fall;

  // Pin drive; released whenever the unit is asynchronous
  always @(posedge aclk) begin
    if (!aresetn) begin
      transfer_clock_pin_o  <= 1'b0;
      transfer_clock_pin_oe <= 1'b0;
    end else begin
      transfer_clock_pin_o  <= xck_int_r;
      transfer_clock_pin_oe <= sync_md && xdir;
    end
  end

  // Ticks per bit minus one; double speed counts only when asynchronous
  wire [3:0]  spb_max  = sync_md ? `USC_SPB_SYNC :
                         (dbl ? `USC_SPB_DBL : `USC_SPB_NORM);

  // ===================================================================
  // Transmitter
  localparam [4:0] TX_IDLE  = 5'b00001;
  localparam [4:0] TX_START = 5'b00010;
  localparam [4:0] TX_DATA  = 5'b00100;
  localparam [4:0] TX_PAR   = 5'b01000;
  localparam [4:0] TX_STOP  = 5'b10000;

  reg  [4:0]  tx_st_r;
  reg  [3:0]  tx_div_r;
  reg  [8:0]  tx_sh_r;
  reg  [3:0]  tx_cnt_r;
  reg         tx_par_r;
  reg         tx_stp_r;
  // Async bit clock from ticks; sync transmitter follows the change edge
  wire        tx_bit   = sync_md ? chg_edge
                                 : (baud_tick && tx_div_r == spb_max);
  wire        tx_load  = tx_bit && txbuf_full_r &&
                         (tx_st_r == TX_IDLE ||
                          (tx_st_r == TX_STOP && (tx_stp_r || !stop2)));
  wire        tx_end   = tx_bit && tx_st_r == TX_STOP && (tx_stp_r || !stop2) &&
                         !txbuf_full_r;

  always @(posedge aclk) begin
    if (!aresetn || !tx_en) begin
      tx_st_r            <= TX_IDLE;
      tx_div_r           <= 4'h0;
      tx_sh_r            <= 9'h000;
      tx_cnt_r           <= 4'h0;
      tx_par_r           <= 1'b0;
      tx_stp_r           <= 1'b0;
      serial_output_line <= 1'b1;
    end else begin
      if (baud_tick) tx_div_r <= (tx_div_r >= spb_max) ? 4'h0 : tx_div_r + 4'h1;
      if (tx_load) begin
        tx_sh_r            <= txbuf_r;
        tx_par_r           <= par_calc(txbuf_r, csize, par_odd);
        tx_stp_r           <= 1'b0;
        serial_output_line <= 1'b0;
        tx_st_r            <= TX_START;
      end else if (tx_bit) begin
        case (tx_st_r)
          TX_IDLE: begin
            serial_output_line <= 1'b1;
          end
          TX_START: begin
            serial_output_line <= tx_sh_r[0];
            tx_sh_r            <= {1'b0, tx_sh_r[8:1]};
            tx_cnt_r           <= 4'h1;
            tx_st_r            <= TX_DATA;
          end
          TX_DATA: begin
            if (tx_cnt_r == nbits) begin
              serial_output_line <= par_on ? tx_par_r : 1'b1;
              tx_st_r            <= par_on ? TX_PAR : TX_STOP;
            end else begin
              serial_output_line <= tx_sh_r[0];
              tx_sh_r            <= {1'b0, tx_sh_r[8:1]};
              tx_cnt_r           <= tx_cnt_r + 4'h1;
            end
          end
          TX_PAR: begin
            serial_output_line <= 1'b1;
            tx_st_r            <= TX_STOP;
          end
          TX_STOP: begin
            serial_output_line <= 1'b1;
            tx_stp_r           <= 1'b1;
            if (tx_stp_r || !stop2) tx_st_r <= TX_IDLE;
          end
          default: begin
            tx_st_r <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // Buffer and completion flag; hardware set beats the software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      txbuf_r      <= 9'h000;
      txbuf_full_r <= 1'b0;
      tx_done_r    <= 1'b0;
    end else begin
      if (tx_load) begin
        txbuf_full_r <= 1'b0;
      end else if (wr_data && !txbuf_full_r) begin
        txbuf_r      <= {ctrl_r[`USC_CTRL_TX9], wdata_r[7:0]};
        txbuf_full_r <= 1'b1;
      end
      if (tx_end) begin
        tx_done_r <= 1'b1;
      end else if (wr_stat && wdata_r[`USC_ST_TXDONE]) begin
        tx_done_r <= 1'b0;
      end
    end
  end

  // ===================================================================
  // Receiver
  localparam [4:0] RX_IDLE  = 5'b00001;
  localparam [4:0] RX_START = 5'b00010;
  localparam [4:0] RX_DATA  = 5'b00100;
  localparam [4:0] RX_PAR   = 5'b01000;
  localparam [4:0] RX_STOP  = 5'b10000;

  reg  [4:0]  rx_st_r;
  reg  [3:0]  rx_div_r;
  reg  [8:0]  rx_sh_r;
  reg  [3:0]  rx_cnt_r;
  reg         rx_perr_r;
  // Async sample at mid bit of the recovery count; sync on the sample edge
  wire        rx_smp   = sync_md ? smp_edge
                                 : (baud_tick && rx_div_r == {1'b0, spb_max[3:1]});
  wire        rx_fin   = rx_smp && rx_st_r == RX_STOP;
  wire        rx_clr   = rd_data;

  always @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      rx_st_r   <= RX_IDLE;
      rx_div_r  <= 4'h0;
      rx_sh_r   <= 9'h000;
      rx_cnt_r  <= 4'h0;
      rx_perr_r <= 1'b0;
    end else begin
      if (baud_tick) rx_div_r <= (rx_div_r >= spb_max) ? 4'h0 : rx_div_r + 4'h1;
      case (rx_st_r)
        RX_IDLE: begin
          rx_cnt_r <= 4'h0;
          rx_sh_r  <= 9'h000;
          if (sync_md && smp_edge && !rxd_r) begin
            rx_st_r <= RX_DATA;
          end else if (!sync_md && baud_tick && !rxd_r) begin
            rx_div_r <= 4'h1;
            rx_st_r  <= RX_START;
          end
        end
        RX_START: begin
          // A start that is gone by mid bit was a glitch
          if (rx_smp) rx_st_r <= rxd_r ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (rx_smp) begin
            rx_sh_r[rx_cnt_r] <= rxd_r;
            rx_cnt_r          <= rx_cnt_r + 4'h1;
            if (rx_cnt_r + 4'h1 == nbits) rx_st_r <= par_on ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (rx_smp) begin
            rx_perr_r <= rxd_r ^ par_calc(rx_sh_r, csize, par_odd);
            rx_st_r   <= RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop is looked at; a second one reads as idle
          if (rx_smp) rx_st_r <= RX_IDLE;
        end
        default: begin
          rx_st_r <= RX_IDLE;
        end
      endcase
      if (rx_fin) rx_perr_r <= 1'b0;
    end
  end

  // Received word and flags; a frame landing on the clearing read wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      rxdata_r  <= 9'h000;
      rx_done_r <= 1'b0;
      frerr_r   <= 1'b0;
      parerr_r  <= 1'b0;
    end else if (rx_fin) begin
      rxdata_r  <= rx_sh_r;
      frerr_r   <= !rxd_r;
      parerr_r  <= rx_perr_r;
      rx_done_r <= 1'b1;
    end else if (rx_clr) begin
      rx_done_r <= 1'b0;
    end
  end

endmodule // usc_core

`default_nettype wire

// ===== verilog/usc_map.vh
`ifndef USC_MAP_VH
`define USC_MAP_VH

// =====================================================================
// Register offsets
`define USC_OFS_CTRL      8'h00
`define USC_OFS_BAUD_LO   8'h04
`define USC_OFS_BAUD_HI   8'h08
`define USC_OFS_DATA      8'h0C
`define USC_OFS_STATUS    8'h10

// =====================================================================
// Control register fields
`define USC_CTRL_RST      13'h0000
`define USC_CTRL_TXEN     0
`define USC_CTRL_RXEN     1
`define USC_CTRL_SYNC     2
`define USC_CTRL_DBL      3
`define USC_CTRL_XDIR     4
`define USC_CTRL_POL      5
`define USC_CTRL_SIZE_LO  6
`define USC_CTRL_SIZE_HI  8
`define USC_CTRL_PAR_LO   9
`define USC_CTRL_PAR_HI   10
`define USC_CTRL_STOP2    11
`define USC_CTRL_TX9      12

// =====================================================================
// Status register fields
`define USC_ST_TXEMPTY    0
`define USC_ST_TXDONE     1
`define USC_ST_RXDONE     2
`define USC_ST_FRERR      3
`define USC_ST_PARERR     4
`define USC_ST_RX9        5

// =====================================================================
// Ticks per bit minus one, and codes
`define USC_SPB_NORM      4'd15
`define USC_SPB_DBL       4'd7
`define USC_SPB_SYNC      4'd1
`define USC_SIZE_NINE     3'd7
`define USC_PAR_EVEN      2'b10
`define USC_PAR_ODD       2'b11
`define USC_RESP_OKAY     2'b00
`define USC_RESP_SLVERR   2'b10

`endif
